// ==== hdl/pcs_params.svh ====
// Purpose: constants of the powerline command sender
// Assumes: 25 MHz system clock
// Notes: function codes are five bits, sent after the house field
//
// Behaviour
// - send start makes modulation pin an output
// - send start makes zero-cross pin an input
// - house letter A..P is value 0..15
// - unit 1..16 is value 0..15 key
// - unit on 10010, unit off 11010
// - all units off 11100, all lamps on 10100
// - dim 11110, bright 10110
// - every frame carries a house code
// - default two repetitions unless count given
// - address unit, then command with same house
// - each one bit is carrier burst at crossing
// - within 50 us of crossing, 22-slot frames
// - transmit only, no receive path
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

`define PCS_CODE_ON 5'h12
`define PCS_CODE_OFF 5'h1a
`define PCS_CODE_ALL_UNITS_OFF 5'h1c
`define PCS_CODE_ALL_LAMPS_ON 5'h14
`define PCS_CODE_DIM 5'h1e
`define PCS_CODE_BRIGHT 5'h16
`define PCS_CODE_TOGGLE 5'h08

`define PCS_DEF_REPS 2
`define PCS_START_CODE 4'he
`define PCS_FRAME_SLOTS 22
`define PCS_GAP_SLOTS 6

`define PCS_CLK_NS 40
`define PCS_CARRIER_KHZ 120
`define PCS_HALF_CYC ((1000000 / (`PCS_CARRIER_KHZ * 2)) / `PCS_CLK_NS)
`define PCS_ALIGN_US 50
`define PCS_ALIGN_CYC ((`PCS_ALIGN_US * 1000) / `PCS_CLK_NS)
`define PCS_BURST_US 1000
`define PCS_BURST_CYC ((`PCS_BURST_US * 1000) / `PCS_CLK_NS)

`endif

// ==== hdl/pcs_pkg.sv ====
// Purpose: types of the powerline command sender
// Assumes: nothing
// Notes: constants live in pcs_params.svh
`default_nettype none
package pcs_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FRAME = 2'b01,
    S_GAP = 2'b10,
    S_NEXT = 2'b11
  } pcs_state_t;
  typedef logic [4:0] pcs_code_t;
endpackage
`default_nettype wire

// ==== hdl/pcs_buf.sv ====
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: same clock on both sides
// Notes: full means in_ready low; storage is flip-flops
`default_nettype none
module pcs_buf
  import pcs_pkg::*;
#(
  parameter int W = 20
)
(
  // clock
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop)
      next_rd_ptr = ~rd_ptr;
    if (push & ~pop)
      next_count = count + 2'h1;
    else if (pop & ~push)
      next_count = count - 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else if (clk_en)
    begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/pcs_sender.sv ====
// Purpose: transmit-only powerline command sender, one frame per entry repetition
// Assumes: zero-cross pin is asynchronous; sys_clk 25 MHz
// Notes: frame is start code then house and key bits as true/complement slot pairs
`include "pcs_params.svh"
`default_nettype none
module pcs_sender
  import pcs_pkg::*;
#(
  parameter int CYC_W = 8,
  parameter int BURST_CYC = `PCS_BURST_CYC,
  parameter int HALF_CYC = `PCS_HALF_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // entry stream
  input wire logic entry_valid,
  output logic entry_ready,
  input wire logic [3:0] entry_house,
  input wire logic entry_is_cmd,
  input wire logic [4:0] entry_key,
  input wire logic [CYC_W-1:0] entry_cycles,
  input wire logic entry_cycles_given,
  input wire logic entry_last,
  // interface pins; no receive path exists
  output logic mod_out,
  output logic mod_oe_b,
  input wire logic zc_in,
  output logic zc_oe_b,
  // status
  output logic busy
);
  // entry packs house, kind, key, count, given flag and last flag
  localparam int ENT_W = 12 + CYC_W;
  localparam int BW = $clog2(BURST_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam logic [4:0] LAST_SLOT = 5'(`PCS_FRAME_SLOTS - 1);
  localparam logic [2:0] LAST_GAP = 3'(`PCS_GAP_SLOTS - 1);

  logic buf_in_ready, buf_valid, pop;
  logic [ENT_W-1:0] buf_data;
  logic [3:0] b_house;
  logic b_is_cmd, b_given, b_last;
  logic [4:0] b_key;
  logic [CYC_W-1:0] b_cycles;

  pcs_buf #(.W(ENT_W)) u_buf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(entry_valid & entry_ready),
    .in_ready(buf_in_ready),
    .in_data({entry_house, entry_is_cmd, entry_key, entry_cycles, entry_cycles_given, entry_last}),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );
  assign {b_house, b_is_cmd, b_key, b_cycles, b_given, b_last} = buf_data;

  // slot pattern: bit 21 goes out first
  function automatic logic [21:0] build_frame(input logic [3:0] house, input logic [4:0] key);
    logic [8:0] data;
    logic [17:0] pairs;
    data = {house, key}; // function codes go out unchanged
    pairs = '0;
    for (int i = 0; i < 9; i++)
      pairs[2*i +: 2] = {data[i], ~data[i]};
    build_frame = {`PCS_START_CODE, pairs};
  endfunction

  // zero-cross synchroniser
  // only the second and third flops feed the edge detector; the first may be metastable
  logic zc_s1, zc_s2, zc_s3, zc_edge;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      zc_s1 <= 1'b0;
      zc_s2 <= 1'b0;
      zc_s3 <= 1'b0;
    end
    else if (clk_en)
    begin
      zc_s1 <= zc_in;
      zc_s2 <= zc_s1;
      zc_s3 <= zc_s2;
    end
  end
  // both mains half-cycles give a crossing
  assign zc_edge = zc_s2 ^ zc_s3;

  // sequencer
  pcs_state_t state, next_state;
  logic [21:0] frame, next_frame;
  logic [4:0] slot, next_slot;
  logic [2:0] gap, next_gap;
  logic [CYC_W-1:0] reps, next_reps;
  logic cur_last, next_cur_last;
  logic list_closed, next_list_closed;
  logic next_mod_oe_b, next_zc_oe_b;
  logic start_burst, load, slot_bit;

  assign load = buf_valid & ((state == S_IDLE) | ((state == S_NEXT) & ~cur_last));
  assign pop = load;
  assign slot_bit = frame[5'd21 - slot];
  assign busy = (state != S_IDLE);
  // a closed list holds off the next one until the last frame is out
  assign entry_ready = buf_in_ready & ~list_closed;

  always_comb
  begin
    next_state = state;
    next_frame = frame;
    next_slot = slot;
    next_gap = gap;
    next_reps = reps;
    next_cur_last = cur_last;
    next_mod_oe_b = mod_oe_b;
    next_zc_oe_b = zc_oe_b;
    next_list_closed = list_closed;
    start_burst = 1'b0;
    if (load)
    begin
      // house always rides along so a later command finds its unit
      next_frame = build_frame(b_house, b_is_cmd ? b_key : {1'b0, b_key[3:0]});
      if (!b_given)
        next_reps = CYC_W'(`PCS_DEF_REPS);
      else if (b_cycles == '0)
        next_reps = CYC_W'(1);
      else
        next_reps = b_cycles;
      next_slot = 5'h0;
      next_cur_last = b_last;
      next_mod_oe_b = 1'b0;
      next_zc_oe_b = 1'b1;
      next_state = S_FRAME;
    end
    else
    begin
      case (state)
        S_FRAME:
          if (zc_edge)
          begin
            start_burst = slot_bit;
            if (slot == LAST_SLOT)
            begin
              next_slot = 5'h0;
              if (reps <= CYC_W'(1))
              begin
                next_gap = 3'h0;
                next_state = S_GAP;
              end
              else
                next_reps = reps - CYC_W'(1);
            end
            else
              next_slot = slot + 5'h1;
          end
        S_GAP:
          if (zc_edge)
          begin
            if (gap == LAST_GAP)
              next_state = S_NEXT;
            else
              next_gap = gap + 3'h1;
          end
        S_NEXT:
          if (cur_last)
            next_state = S_IDLE;
        default:
          next_state = S_IDLE; // crossings ignored while idle
      endcase
    end
    // set wins over clear
    if ((state == S_NEXT) & cur_last)
      next_list_closed = 1'b0;
    if (entry_valid & entry_ready & entry_last)
      next_list_closed = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      frame <= '0;
      slot <= 5'h0;
      gap <= 3'h0;
      reps <= '0;
      cur_last <= 1'b0;
      list_closed <= 1'b0;
      mod_oe_b <= 1'b1;
      zc_oe_b <= 1'b1;
    end
    else if (clk_en)
    begin
      state <= next_state;
      frame <= next_frame;
      slot <= next_slot;
      gap <= next_gap;
      reps <= next_reps;
      cur_last <= next_cur_last;
      list_closed <= next_list_closed;
      mod_oe_b <= next_mod_oe_b;
      zc_oe_b <= next_zc_oe_b;
    end
  end

  // carrier burst generator
  // burst must end before the next crossing, so BURST_CYC stays under a half mains period
  logic [BW-1:0] burst_cnt, next_burst_cnt;
  logic [HW-1:0] half_cnt, next_half_cnt;
  logic next_mod_out;

  always_comb
  begin
    next_burst_cnt = burst_cnt;
    next_half_cnt = half_cnt;
    next_mod_out = 1'b0;
    if (start_burst)
    begin
      next_burst_cnt = BW'(BURST_CYC);
      next_half_cnt = '0;
      next_mod_out = 1'b1;
    end
    else if (burst_cnt != '0)
    begin
      next_burst_cnt = burst_cnt - BW'(1);
      next_mod_out = mod_out;
      if (half_cnt == HW'(HALF_CYC - 1))
      begin
        next_half_cnt = '0;
        next_mod_out = ~mod_out;
      end
      else
        next_half_cnt = half_cnt + HW'(1);
      if (burst_cnt == BW'(1))
        next_mod_out = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      burst_cnt <= '0;
      half_cnt <= '0;
      mod_out <= 1'b0;
    end
    else if (clk_en)
    begin
      burst_cnt <= next_burst_cnt;
      half_cnt <= next_half_cnt;
      mod_out <= next_mod_out;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_idle_quiet: assert property (state == S_IDLE && burst_cnt == '0 |-> !mod_out)
    else $error("modulation active while idle");
  a_burst_align: assert property (clk_en && state == S_FRAME && zc_edge && slot_bit && !load |=> mod_out)
    else $error("burst did not start at crossing");
  a_zero_slot_quiet: assert property (clk_en && state == S_FRAME && zc_edge && !slot_bit && burst_cnt == '0
    |=> !mod_out)
    else $error("burst on a zero slot");
  a_pin_output: assert property (busy |-> !mod_oe_b && zc_oe_b)
    else $error("pin direction wrong during send");
  a_house_field: assert property (clk_en && load |=> frame[21:18] == `PCS_START_CODE
    && frame[17] == $past(b_house[3]) && frame[16] != frame[17])
    else $error("house field not in frame");
  a_unit_key: assert property (clk_en && load && !b_is_cmd |=> frame[9:8] == 2'b01
    && frame[1] == $past(b_key[0]))
    else $error("unit key field wrong");
  a_default_reps: assert property (clk_en && load && !b_given |=> reps == CYC_W'(`PCS_DEF_REPS))
    else $error("default repetition count not two");
  a_toggle_code: assert property ((`PCS_CODE_ON ^ `PCS_CODE_TOGGLE) == `PCS_CODE_OFF
    && `PCS_CODE_ALL_UNITS_OFF != `PCS_CODE_ALL_LAMPS_ON && `PCS_CODE_DIM != `PCS_CODE_BRIGHT)
    else $error("function code layout broken");
  a_busy_end: assert property ($fell(busy) |-> $past(state) == S_NEXT && $past(cur_last))
    else $error("busy dropped early");
  a_list_hold: assert property (list_closed |-> !entry_ready)
    else $error("new list accepted while busy");
  a_gap_quiet: assert property (clk_en && state == S_GAP && zc_edge |-> burst_cnt == '0)
    else $error("burst overran into gap");
  // frame slots: bit 21 first, house pairs at 17..10, key pairs at 9..0
  a_cmd_key: assert property (clk_en && load && b_is_cmd
    |=> {frame[9], frame[7], frame[5], frame[3], frame[1]} == $past(b_key))
    else $error("function code field wrong");
  a_house_low: assert property (clk_en && load |=> frame[11] == $past(b_house[0]) && frame[10] != frame[11])
    else $error("house low bit wrong");
  a_reps_next: assert property (clk_en && !load && state == S_FRAME && zc_edge && slot == LAST_SLOT && reps > CYC_W'(1)
    |=> state == S_FRAME && slot == 5'h0 && reps == $past(reps) - CYC_W'(1))
    else $error("repetition not sent again");
  a_oe_on_send: assert property ($fell(mod_oe_b) |-> busy)
    else $error("modulation pin enabled outside a send");
  a_zc_input: assert property (zc_oe_b)
    else $error("zero-cross pin driven");

  c_load: cover property (load && b_is_cmd && b_given);
  c_list_done: cover property ($fell(busy));
  c_chain: cover property (clk_en && state == S_NEXT && load);
  c_dim: cover property (clk_en && load && b_is_cmd && b_key == `PCS_CODE_DIM);
endmodule
`default_nettype wire

// ==== testbench/pcs_line_model.sv ====
// Purpose: powerline interface model, crossing source and burst detector
// Assumes: mains crossings run free, also during reset
// Notes: a slot counts as one only if the carrier rose twice or more
`default_nettype none
module pcs_line_model #(
  parameter int ZC_HALF = 40,
  parameter int LATE_MAX = 8
)
(
  // interface pins
  input wire logic sys_clk,
  input wire logic mod_out,
  input wire logic mod_oe_b,
  output logic zc_in,
  // decoded slots
  output logic slot_strobe,
  output logic slot_bit,
  output logic late
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int rises = 0;
  int first = 0;
  logic mod_q = 1'b0;
  logic zc_q = 1'b0;
  logic strobe_q = 1'b0;
  logic bit_q = 1'b0;
  logic late_q = 1'b0;

  assign zc_in = zc_q;
  assign slot_strobe = strobe_q;
  assign slot_bit = bit_q;
  assign late = late_q;

  always @(posedge sys_clk)
  begin
    strobe_q <= 1'b0;
    mod_q <= mod_out;
    if (cnt == ZC_HALF - 1)
    begin
      cnt <= 0;
      zc_q <= ~zc_q;
      strobe_q <= 1'b1;
      bit_q <= (rises >= 2);
      late_q <= (rises > 0) && (first > LATE_MAX);
      rises <= 0;
      first <= 0;
    end
    else
    begin
      cnt <= cnt + 1;
      // an undriven pin carries no carrier
      if (mod_out && !mod_q && !mod_oe_b)
      begin
        rises <= rises + 1;
        if (rises == 0)
          first <= cnt;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pcs_sender_test.sv ====
// Purpose: self-checking bench for the powerline command sender
// Assumes: line model toggles the crossing pin every 40 clocks
// Notes: frames are rebuilt from slot bits and compared in order
`include "pcs_params.svh"
`default_nettype none
module pcs_sender_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic entry_valid = 1'b0;
  logic entry_is_cmd = 1'b0;
  logic entry_cycles_given = 1'b0;
  logic entry_last = 1'b0;
  logic [3:0] entry_house = 4'h0;
  logic [4:0] entry_key = 5'h00;
  logic [7:0] entry_cycles = 8'h00;
  logic entry_ready, mod_out, mod_oe_b, zc_in, zc_oe_b, busy, slot_strobe, slot_bit, late;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int nb = 0;
  int refused = 0;
  int lamp_dim = 0;
  logic lamp_on = 1'b0;
  logic [4:0] lamp_code = 5'h00;
  int seed = 32'h2f9f8a47;
  logic [21:0] fr = 22'h000000;
  logic [21:0] exp_q[$];
  logic [4:0] codes [6] = '{`PCS_CODE_ON, `PCS_CODE_OFF, `PCS_CODE_ALL_UNITS_OFF,
    `PCS_CODE_ALL_LAMPS_ON, `PCS_CODE_DIM, `PCS_CODE_BRIGHT};

  pcs_sender #(.CYC_W(8), .BURST_CYC(20), .HALF_CYC(2)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .entry_valid(entry_valid),
    .entry_ready(entry_ready), .entry_house(entry_house), .entry_is_cmd(entry_is_cmd),
    .entry_key(entry_key), .entry_cycles(entry_cycles), .entry_cycles_given(entry_cycles_given),
    .entry_last(entry_last), .mod_out(mod_out), .mod_oe_b(mod_oe_b), .zc_in(zc_in),
    .zc_oe_b(zc_oe_b), .busy(busy));

  pcs_line_model #(.ZC_HALF(40), .LATE_MAX(8)) u_line (
    .sys_clk(sys_clk), .mod_out(mod_out), .mod_oe_b(mod_oe_b), .zc_in(zc_in),
    .slot_strobe(slot_strobe), .slot_bit(slot_bit), .late(late));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // start code, then each house and key bit as true and complement
  function automatic logic [21:0] frame(input logic [8:0] hk);
    logic [21:0] f;
    f = 22'h00000e;
    for (int i = 8; i >= 0; i--)
      f = {f[19:0], hk[i], ~hk[i]};
    return f;
  endfunction

  task automatic send(input logic [3:0] h, input logic c, input logic [4:0] k, input logic g,
    input logic [7:0] n, input logic l);
    int reps;
    reps = g ? ((n == 0) ? 1 : int'(n)) : `PCS_DEF_REPS;
    entry_valid = 1'b1;
    entry_house = h;
    entry_is_cmd = c;
    entry_key = k;
    entry_cycles_given = g;
    entry_cycles = n;
    entry_last = l;
    // ready is looked at once settled, before the edge that takes the entry
    while (entry_ready !== 1'b1)
    begin
      refused++;
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
    repeat (reps) exp_q.push_back(frame({h, c ? k : {1'b0, k[3:0]}}));
  endtask

  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      final_report;
    end
  end

  // idle crossings that raise a burst show up here as an unexpected frame
  always @(posedge sys_clk)
    if (slot_strobe === 1'b1)
    begin
      check("burst delay", late, 0);
      if (nb > 0 || slot_bit === 1'b1)
      begin
        fr = {fr[20:0], slot_bit};
        nb++;
      end
      if (nb == 22)
      begin
        nb = 0;
        check("frame", fr, (exp_q.size() > 0) ? exp_q.pop_front() : 22'h000000);
        // far-end dimmer acts on every command frame; unit frames carry bit 4 low
        lamp_code = {fr[9], fr[7], fr[5], fr[3], fr[1]};
        if (lamp_code == `PCS_CODE_OFF || lamp_code == `PCS_CODE_ALL_UNITS_OFF)
        begin
          lamp_on = 1'b0;
          lamp_dim = 0;
        end
        else if (!lamp_on && lamp_dim == 0 && lamp_code[4])
          lamp_on = 1'b1;
        else if (lamp_code == `PCS_CODE_DIM && lamp_on && lamp_dim < 19)
          lamp_dim++;
        else if (lamp_code == `PCS_CODE_BRIGHT && lamp_dim > 0)
          lamp_dim--;
      end
    end

  initial
  begin
    logic [3:0] h;
    logic [3:0] u;
    logic [7:0] n;
    repeat (11) @(posedge sys_clk);
    #1;
    check("reset mod_out", mod_out, 0);
    check("reset mod_oe_b", mod_oe_b, 1);
    check("reset busy", busy, 0);
    check("reset ready", entry_ready, 1);
    @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (300) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 6; i++)
    begin
      h = 4'($random(seed));
      u = 4'($random(seed));
      n = 8'($random(seed) & 3);
      refused = 0;
      send(h, 1'b0, {1'b0, u}, 1'b1, 8'h02, 1'b0);
      send(h, 1'b1, `PCS_CODE_OFF, 1'b1, 8'h02, 1'b0);
      send(h, 1'b1, `PCS_CODE_OFF ^ `PCS_CODE_TOGGLE, 1'b1, 8'h02, 1'b0);
      send(h, 1'b1, codes[i], 1'(i), n, 1'b1);
      entry_valid = 1'b0;
      check("ready after last", entry_ready, 0);
      check("buffer refused", refused > 0, 1);
      check("busy", busy, 1);
      check("mod_oe_b", mod_oe_b, 0);
      check("zc_oe_b", zc_oe_b, 1);
      while (busy === 1'b1)
        @(posedge sys_clk);
      #1;
      check("ready when idle", entry_ready, 1);
      check("frames left", exp_q.size(), 0);
      check("lamp on", lamp_on, (i == 0 || i >= 3));
      check("lamp dim", lamp_dim, (i == 4) ? `PCS_DEF_REPS : 0);
      repeat (200) @(posedge sys_clk);
      #1;
      check("idle mod_out", mod_out, 0);
    end
    final_report;
  end
endmodule
`default_nettype wire
